// File: include/sut_defs.svh
// Purpose: register offsets, field positions and reset values
// Assumes: 32-bit APB data, byte addresses
// Notes: definitions only
`ifndef SUT_DEFS_SVH
`define SUT_DEFS_SVH

`define SUT_OFS_UPDATE    8'h0C
`define SUT_OFS_CTRL      8'h10
`define SUT_OFS_RELOAD    8'h14
`define SUT_OFS_CURRENT   8'h18

`define SUT_UPD_CLR_BIT   31
`define SUT_UPD_RSV_MSB   30
`define SUT_UPD_RSV_LSB   2
`define SUT_UPD_GEN_BIT   1
`define SUT_UPD_GLB_BIT   0

`define SUT_CTL_PEN_BIT   15
`define SUT_CTL_PSC_MSB   5
`define SUT_CTL_PSC_LSB   2
`define SUT_CTL_MODE_BIT  1
`define SUT_CTL_START_BIT 0

`define SUT_PSC_RESET     4'hF
`define SUT_MAX_DIV_CODE  4'hC
`define SUT_RELOAD_RESET  16'h0000
`define SUT_VALUE_RESET   16'h0000

`endif

// File: include/sut_pkg.sv
// Purpose: types of the update control and report timer
// Assumes: nothing
// Notes: one packed struct holds all state
`default_nettype none

package sut_pkg;

  typedef enum logic [1:0]
  {
    SUT_IDLE   = 2'b01,
    SUT_OUTPUT = 2'b10
  } sut_fsm_e;

  typedef struct packed
  {
    logic        ref_s1;
    logic        ref_s2;
    logic        ref_s3;
    logic [12:0] pre_cnt;
    logic [15:0] val;
    logic [15:0] reload;
    logic        start;
    logic        mode;
    logic        pre_en;
    logic [3:0]  pre_code;
    logic        clr_after;
    logic [28:0] upd_rsvd;
    logic        gen;
    logic        glb;
    logic        glb_armed;
    logic        pend;
    logic        phase_clr;
    sut_fsm_e    fsm;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        report_req;
    logic        mask_clr;
    logic        zero_req;
    logic        stream_en;
  } sut_state_s;

endpackage

`default_nettype wire

// File: hw/sut_stats_update_timer.sv
// Purpose: counter update control and report timer behind an APB slave
// Assumes: timer_ref_in is asynchronous; phase-done comes from the same clock
// Notes: one wait state on every APB access
//
// Notes on behaviour
// - after a report phase, clear_after_report set zeroes all counters, else masks rule.
// - direct register reads of statistics never trigger the counter zeroing.
// - writing one to generate_report emits a report regardless of timer state.
// - generate_report stays set until the output phase has finished.
// - writing one to global_clear zeroes all active bit masks.
// - global_clear stays set until the following update's output phase completes.
// - global_clear with generate_report reports now; alone it waits for next update.
// - both bits written together act like an all-zero-map send-update command.
// - prescaler passes the reference only when prescaler enable is one.
// - prescale code n divides the reference by two to the power n+1.
// - the three highest prescale codes disable the timer; reset code is all ones.
// - one-shot mode clears start and stops on expiry.
// - auto-load mode reloads the load value on expiry and keeps counting.
// - the 16-bit timer counts down while start is one, halts at zero write.
// - load value is a read-write 16-bit field resetting to zero.
// - live count reads in bits 15 to 0, upper bits zero, resets zero.
// - with engine disabled no increments and both streams stay disabled.
//
// The address map and the APB slave port are this design's own decisions.
`include "sut_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sut_stats_update_timer
#(
  parameter logic [3:0] MAX_DIV_CODE = `SUT_MAX_DIV_CODE
)
(
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output var  logic [31:0] prdata_out,
  output var  logic        pready_out,
  output var  logic        pslverr_out,
  input  wire logic        engine_enable_in,
  input  wire logic        timer_ref_in,
  input  wire logic        output_phase_done_in,
  output var  logic        report_request_out,
  output var  logic        mask_clear_out,
  output var  logic        counters_zero_out,
  output var  logic        stream_enable_out
);
  import sut_pkg::*;

  if (MAX_DIV_CODE > 4'hC)
  begin : g_chk
    $error("MAX_DIV_CODE above 12 cannot be served");
  end

  sut_state_s  st;
  sut_state_s  nx;
  logic        acc;
  logic        wr;
  logic        hit;
  logic        wr_upd;
  logic        wr_ctl;
  logic        wr_rld;
  logic [31:0] rd_data;
  logic        ref_tick;
  logic [12:0] div_mask;
  logic        div_hit;
  logic        code_ok;
  logic        tmr_tick;
  logic        phase_end;

  assign acc       = psel_in && penable_in;
  assign wr        = acc && pwrite_in && st.pready;
  assign wr_upd    = wr && (paddr_in == `SUT_OFS_UPDATE);
  assign wr_ctl    = wr && (paddr_in == `SUT_OFS_CTRL);
  assign wr_rld    = wr && (paddr_in == `SUT_OFS_RELOAD);
  assign hit       = (paddr_in == `SUT_OFS_UPDATE) || (paddr_in == `SUT_OFS_CTRL)
                  || (paddr_in == `SUT_OFS_RELOAD) || (paddr_in == `SUT_OFS_CURRENT);
  assign phase_end = (st.fsm == SUT_OUTPUT) && output_phase_done_in;

  // register read mux
  assign rd_data =
    (paddr_in == `SUT_OFS_UPDATE)  ? {st.clr_after, st.upd_rsvd, st.gen, st.glb} :
    (paddr_in == `SUT_OFS_CTRL)    ? {16'h0000, st.pre_en, 9'h000, st.pre_code,
                                      st.mode, st.start} :
    (paddr_in == `SUT_OFS_RELOAD)  ? {16'h0000, st.reload} :
    (paddr_in == `SUT_OFS_CURRENT) ? {16'h0000, st.val} :
    32'h0000_0000;

  // edge of the synchronised reference
  assign ref_tick = st.ref_s2 && !st.ref_s3;

  assign div_mask = (13'h0002 << st.pre_code) - 13'h0001;
  assign div_hit  = (st.pre_cnt & div_mask) == div_mask;
  assign code_ok  = st.pre_code <= MAX_DIV_CODE;
  // prescaler in path only when enabled
  assign tmr_tick = ref_tick && code_ok && (!st.pre_en || div_hit);

  always_comb
  begin
    nx            = st;
    nx.ref_s1     = timer_ref_in;
    nx.ref_s2     = st.ref_s1;
    nx.ref_s3     = st.ref_s2;
    nx.report_req = 1'b0;
    nx.mask_clr   = 1'b0;
    nx.zero_req   = 1'b0;
    nx.stream_en  = engine_enable_in;

    nx.pready = acc && !st.pready;
    if (acc && !st.pready)
    begin
      nx.pslverr = !hit;
      nx.prdata  = pwrite_in ? 32'h0000_0000 : rd_data;
    end

    if (!st.pre_en)
    begin
      nx.pre_cnt = 13'h0000;
    end
    else if (ref_tick)
    begin
      nx.pre_cnt = st.pre_cnt + 13'h0001;
    end

    unique case (st.fsm)
      SUT_IDLE:
      begin
        if (engine_enable_in && (st.gen || st.pend))
        begin
          nx.report_req = 1'b1;
          nx.pend       = 1'b0;
          nx.glb_armed  = st.glb;
          nx.phase_clr  = st.clr_after;
          nx.fsm        = SUT_OUTPUT;
        end
      end
      SUT_OUTPUT:
      begin
        if (output_phase_done_in)
        begin
          nx.gen = 1'b0;
          if (st.glb_armed)
          begin
            nx.glb = 1'b0;
          end
          nx.glb_armed = 1'b0;
          nx.zero_req  = st.phase_clr;
          nx.fsm       = SUT_IDLE;
        end
      end
    endcase

    if (tmr_tick && st.start)
    begin
      if (st.val == 16'h0000)
      begin
        nx.pend = 1'b1;
        if (st.mode)
        begin
          nx.val = st.reload;
        end
        else
        begin
          nx.start = 1'b0;
        end
      end
      else
      begin
        nx.val = st.val - 16'h0001;
      end
    end

    // register writes come last so a set beats a clear
    if (wr_upd)
    begin
      nx.clr_after = pwdata_in[`SUT_UPD_CLR_BIT];
      nx.upd_rsvd  = pwdata_in[`SUT_UPD_RSV_MSB:`SUT_UPD_RSV_LSB];
      if (pwdata_in[`SUT_UPD_GEN_BIT])
      begin
        nx.gen = 1'b1;
      end
      if (pwdata_in[`SUT_UPD_GLB_BIT])
      begin
        nx.glb      = 1'b1;
        nx.mask_clr = 1'b1;
      end
    end
    if (wr_ctl)
    begin
      nx.pre_en   = pwdata_in[`SUT_CTL_PEN_BIT];
      nx.pre_code = pwdata_in[`SUT_CTL_PSC_MSB:`SUT_CTL_PSC_LSB];
      nx.mode     = pwdata_in[`SUT_CTL_MODE_BIT];
      nx.start    = pwdata_in[`SUT_CTL_START_BIT];
      if (pwdata_in[`SUT_CTL_START_BIT] && !st.start)
      begin
        nx.val = st.reload;
      end
    end
    if (wr_rld)
    begin
      nx.reload = pwdata_in[15:0];
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st           <= '0;
      st.pre_code  <= `SUT_PSC_RESET;
      st.reload    <= `SUT_RELOAD_RESET;
      st.val       <= `SUT_VALUE_RESET;
      st.fsm       <= SUT_IDLE;
    end
    else
    begin
      st <= nx;
    end
  end

  assign prdata_out         = st.prdata;
  assign pready_out         = st.pready;
  assign pslverr_out        = st.pslverr;
  assign report_request_out = st.report_req;
  assign mask_clear_out     = st.mask_clr;
  assign counters_zero_out  = st.zero_req;
  assign stream_enable_out  = st.stream_en;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_gen_bit_held: assert property (
    st.gen && !phase_end |=> st.gen)
    else $error("generate bit dropped early");

  a_gen_bit_release: assert property (
    phase_end && !(wr_upd && pwdata_in[1]) |=> !st.gen && st.fsm == SUT_IDLE)
    else $error("generate bit not released");

  a_gen_report_now: assert property (
    st.fsm == SUT_IDLE && st.gen && engine_enable_in
    |=> st.report_req && st.fsm == SUT_OUTPUT)
    else $error("manual report not issued");

  a_glb_mask_clear: assert property (
    wr_upd && pwdata_in[0] |=> st.mask_clr && st.glb)
    else $error("global clear not applied");

  a_glb_alone_defer: assert property (
    wr_upd && pwdata_in[0] && !pwdata_in[1] && !st.gen && !st.pend
    && st.fsm == SUT_IDLE |=> !st.report_req)
    else $error("global clear alone made a report");

  a_zero_after_rep: assert property (
    phase_end |=> st.zero_req == $past(st.phase_clr))
    else $error("zeroing after report wrong");

  a_zero_cause_only: assert property (
    st.zero_req |-> $past(phase_end))
    else $error("zeroing without report phase");

  a_oneshot_stop: assert property (
    tmr_tick && st.start && !st.mode && st.val == 16'h0000 && !wr_ctl
    |=> !st.start && $stable(st.val))
    else $error("one-shot did not stop");

  a_autoload_expiry: assert property (
    tmr_tick && st.start && st.mode && st.val == 16'h0000 && !wr_ctl
    |=> st.start && st.val == $past(st.reload))
    else $error("auto-load did not reload");

  a_code_disables: assert property (
    !code_ok && !wr_ctl |=> $stable(st.val))
    else $error("timer moved with disabled code");

  a_count_step: assert property (
    tmr_tick && st.start && st.val != 16'h0000 && !wr_ctl
    |=> st.val == $past(st.val) - 16'h0001)
    else $error("timer step wrong");

  a_stream_disable: assert property (
    !engine_enable_in |=> !st.stream_en && !st.report_req)
    else $error("stream active while disabled");

  a_current_read: assert property (
    acc && !st.pready && !pwrite_in && paddr_in == `SUT_OFS_CURRENT
    |=> st.pready && st.prdata == {16'h0000, $past(st.val)})
    else $error("current value read wrong");

  a_mask_cause: assert property (
    st.mask_clr |-> $past(wr_upd && pwdata_in[0]))
    else $error("mask clear without global clear write");

  a_glb_held: assert property (
    st.glb && !(phase_end && st.glb_armed) |=> st.glb)
    else $error("global clear dropped early");

  a_glb_release: assert property (
    phase_end && st.glb_armed && !(wr_upd && pwdata_in[0]) |=> !st.glb)
    else $error("global clear not released");

  a_report_single: assert property (
    st.report_req |=> !st.report_req)
    else $error("report request longer than one cycle");

  a_expiry_pending: assert property (
    tmr_tick && st.start && st.val == 16'h0000 |=> st.pend)
    else $error("expiry did not leave a pending report");

  a_pend_served: assert property (
    st.fsm == SUT_IDLE && st.pend && engine_enable_in |=> st.report_req)
    else $error("pending report not issued");

  a_start_load: assert property (
    wr_ctl && pwdata_in[0] && !st.start |=> st.val == $past(st.reload))
    else $error("start did not load the count");

  a_pre_off_hold: assert property (
    !st.pre_en |=> st.pre_cnt == 13'h0000)
    else $error("prescaler ran while disabled");

  a_div_two_min: assert property (
    tmr_tick && st.pre_en |-> st.pre_cnt[0])
    else $error("prescaled tick faster than divide by two");

  a_reload_write: assert property (
    wr_rld |=> st.reload == $past(pwdata_in[15:0]))
    else $error("load value not stored");

  a_stream_follow: assert property (
    engine_enable_in |=> st.stream_en)
    else $error("stream not enabled with engine");

  a_stop_halts: assert property (
    !st.start && !wr_ctl |=> $stable(st.val))
    else $error("timer moved while stopped");

  c_autoload: cover property (
    tmr_tick && st.start && st.mode && st.val == 16'h0000);
  c_both_bits: cover property (
    wr_upd && pwdata_in[1] && pwdata_in[0]);
  c_report_done: cover property (
    st.report_req ##[1:20] phase_end);
  c_oneshot: cover property (
    tmr_tick && st.start && !st.mode && st.val == 16'h0000);
  c_expiry_in_phase: cover property (
    st.fsm == SUT_OUTPUT && tmr_tick && st.start && st.val == 16'h0000);

endmodule

`default_nettype wire

// File: dv/test_sut_stats_update_timer.sv
// Purpose: self-checking bench for the update control and report timer
// Assumes: one wait state APB slave, free-running timer reference
// Notes: register table loop first, then report and timer cases
`include "sut_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module test_sut_stats_update_timer;
  typedef struct packed
  {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] e;
    logic        err;
  } sut_row_s;

  logic        clk  = 0;
  logic        rst  = 1;
  logic        psel = 0;
  logic        pen  = 0;
  logic        pwr  = 0;
  logic [7:0]  pa   = 0;
  logic [31:0] pwd  = 0;
  logic        eng  = 0;
  logic        tref = 0;
  logic        done = 0;
  logic [31:0] prd;
  logic        prdy;
  logic        perr;
  logic        req;
  logic        mclr;
  logic        czero;
  logic        sen;
  logic [31:0] rd;
  logic [31:0] v;
  logic        er;
  logic        f;
  int          n;
  int          miscompares = 0;
  int          n_compared  = 0;
  sut_row_s    rows [5] = '{
    '{8'h14, 32'h1234ABCD, 32'h0000ABCD, 1'b0},
    '{8'h10, 32'hFFFF003E, 32'h0000003E, 1'b0},
    '{8'h18, 32'hFFFFFFFF, 32'h00000000, 1'b0},
    '{8'h0C, 32'h7FFFFFFC, 32'h7FFFFFFC, 1'b0},
    '{8'h20, 32'hFFFFFFFF, 32'h00000000, 1'b1}};
  logic [31:0] tr [3] = '{32'h7, 32'h3, 32'h1};
  logic [31:0] tc [3] = '{32'h1, 32'h8001, 32'h8005};

  sut_stats_update_timer u_sut_stats_update_timer
  (
    .sys_clk_in           (clk),
    .sys_rst_in           (rst),
    .psel_in              (psel),
    .penable_in           (pen),
    .pwrite_in            (pwr),
    .paddr_in             (pa),
    .pwdata_in            (pwd),
    .prdata_out           (prd),
    .pready_out           (prdy),
    .pslverr_out          (perr),
    .engine_enable_in     (eng),
    .timer_ref_in         (tref),
    .output_phase_done_in (done),
    .report_request_out   (req),
    .mask_clear_out       (mclr),
    .counters_zero_out    (czero),
    .stream_enable_out    (sen)
  );

  initial forever #10 clk = ~clk;

  initial
  begin
    forever
    begin
      repeat (2) @(posedge clk);
      tref <= ~tref;
    end
  end

  task summarize();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    logic got;
    got = 0;
    r   = 32'h0;
    e   = 1'b0;
    @(posedge clk);
    psel <= 1;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1;
    for (int k = 0; k < 20 && !got; k++)
    begin
      @(posedge clk);
      if (prdy === 1'b1)
      begin
        got = 1;
        r   = prd;
        e   = perr;
      end
    end
    psel <= 0;
    pen  <= 0;
    if (!got)
    begin
      miscompares++;
      summarize();
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, e);
  endtask

  task wait_sig(input int s, input int mx, output logic fnd, output int cnt);
    fnd = 0;
    for (cnt = 0; cnt < mx && !fnd; cnt++)
    begin
      @(negedge clk);
      case (s)
        0:       fnd = (req === 1'b1);
        1:       fnd = (mclr === 1'b1);
        default: fnd = (czero === 1'b1);
      endcase
    end
  endtask

  task pulse_done();
    @(posedge clk);
    done <= 1;
    @(posedge clk);
    done <= 0;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, rows[i].a, rows[i].w, rd, er);
      chk(er, rows[i].err);
      rdc(rows[i].a, rows[i].e);
      chk(er, rows[i].err);
    end
    $display("register table test done");
    @(posedge clk) rst <= 1;
    @(posedge clk) rst <= 0;
    rdc(`SUT_OFS_UPDATE, 32'h0);
    rdc(`SUT_OFS_CTRL, 32'h3C);
    rdc(`SUT_OFS_RELOAD, 32'h0);
    rdc(`SUT_OFS_CURRENT, 32'h0);
    $display("reset value test done");
    // update writes only with engine off
    wr(`SUT_OFS_UPDATE, 32'h80000003);
    wait_sig(1, 10, f, n);
    chk(f, 1);
    wait_sig(0, 20, f, n);
    chk(f, 0);
    chk(sen, 0);
    @(posedge clk) eng <= 1;
    wait_sig(0, 10, f, n);
    chk(f, 1);
    chk(sen, 1);
    rdc(`SUT_OFS_UPDATE, 32'h80000003);
    pulse_done();
    wait_sig(2, 5, f, n);
    chk(f, 1);
    rdc(`SUT_OFS_UPDATE, 32'h80000000);
    @(posedge clk) eng <= 0;
    wr(`SUT_OFS_UPDATE, 32'h1);
    wait_sig(1, 10, f, n);
    chk(f, 1);
    @(posedge clk) eng <= 1;
    wait_sig(0, 20, f, n);
    chk(f, 0);
    rdc(`SUT_OFS_UPDATE, 32'h1);
    @(posedge clk) eng <= 0;
    wr(`SUT_OFS_UPDATE, 32'h2);
    @(posedge clk) eng <= 1;
    wait_sig(0, 10, f, n);
    chk(f, 1);
    pulse_done();
    wait_sig(2, 5, f, n);
    chk(f, 0);
    rdc(`SUT_OFS_UPDATE, 32'h0);
    $display("report control test done");
    for (int i = 0; i < 3; i++)
    begin
      wr(`SUT_OFS_CTRL, 32'h0);
      wr(`SUT_OFS_RELOAD, tr[i]);
      wr(`SUT_OFS_CTRL, tc[i]);
      wait_sig(0, 80, f, n);
      chk(f, 1);
      chk(n >= 24 && n <= 46, 1);
      pulse_done();
      rdc(`SUT_OFS_CTRL, tc[i] & 32'hFFFFFFFE);
    end
    $display("one-shot prescale test done");
    wr(`SUT_OFS_RELOAD, 32'h2);
    wr(`SUT_OFS_CTRL, 32'h37);
    wait_sig(0, 60, f, n);
    chk(f, 0);
    rdc(`SUT_OFS_CURRENT, 32'h2);
    wr(`SUT_OFS_CTRL, 32'h3);
    wait_sig(0, 60, f, n);
    chk(f, 1);
    pulse_done();
    wait_sig(0, 60, f, n);
    chk(f, 1);
    pulse_done();
    rdc(`SUT_OFS_CTRL, 32'h3);
    wr(`SUT_OFS_CTRL, 32'h2);
    apb(1'b0, `SUT_OFS_CURRENT, 32'h0, v, er);
    chk(v[31:16], 0);
    repeat (40) @(posedge clk);
    rdc(`SUT_OFS_CURRENT, v);
    $display("auto-load and stop test done");
    summarize();
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule

`default_nettype wire
